// ===== logic/swg_status_event_log.sv
// Purpose: breaker condition alarms, counters, operation log and indicator monitors with time-stamped events
// Assumes: all inputs synchronous to CLK_SYS_IN; wear figures arrive already computed
// Notes: events leave one per cycle on EVT_OUT; the event buffer holds one pending edge per source and direction
`timescale 1ns/1ps
`default_nettype none
module swg_status_event_log #(
  parameter int NI = 10,
  parameter int MS_CYCLES = swg_pkg::CLK_PER_MS
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire swg_pkg::swg_brk_type BRK_IN,
  input wire swg_pkg::swg_wear_type WEAR_IN,
  input wire logic [NI-1:0] IND_OPEN_IN,
  input wire logic [NI-1:0] IND_CLOSE_IN,
  output swg_pkg::swg_evt_type EVT_OUT,
  output swg_pkg::swg_alarm_type ALARM_OUT,
  output logic [2*NI-1:0] IND_STATUS_OUT,
  output logic IRQ_OUT
);
  import swg_pkg::*;

  typedef struct packed {
    logic [31:0] div;
    logic [31:0] ms;
    logic tick;
    logic [SRC_W-1:0] src_prev;
    logic [SRC_W-1:0] pend_on;
    logic [SRC_W-1:0] pend_off;
    logic [31:0] stamp;
    swg_evt_type evt;
    logic setup;
    logic alm1_en;
    logic alm2_en;
    logic [31:0] alm1_thr;
    logic [31:0] alm2_thr;
    logic [31:0] warn_thr;
    logic [31:0] abr_thr;
    logic [3:0][31:0] cnt;
    logic [NI-1:0] ind_single;
    logic [NI-1:0][1:0] ind_stat;
    logic [1:0] obj_pos;
    logic [1:0] wd_pos;
    logic [SRC_W-1:0] rise_en;
    logic [SRC_W-1:0] fall_en;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
    swg_alarm_type alarm;
    logic o_run;
    logic c_run;
    logic [31:0] o_time;
    logic [31:0] c_time;
    logic [31:0] o_last;
    logic [31:0] c_last;
    logic [LOG_DEPTH-1:0] [$bits(swg_log_type)-1:0] log_mem;
    logic [3:0] wp;
    logic [3:0] used;
    logic [3:0] sel;
    logic [31:0] rdata;
    logic waitreq;
  } swg_state_type;

  swg_state_type s;
  swg_state_type next_s;

  // entry index counted back from the newest
  function automatic logic [3:0] log_index(input logic [3:0] wp, input logic [3:0] sel);
    return 4'((int'(wp) + 2 * LOG_DEPTH - 1 - int'(sel)) % LOG_DEPTH);
  endfunction

  // register value for one address; unmapped locations read as zero
  function automatic logic [31:0] read_reg(input swg_state_type st, input logic [7:0] addr);
    logic [31:0] v;
    swg_log_type e;
    v = 32'h00000000;
    e = swg_log_type'(st.log_mem[log_index(st.wp, st.sel)]);
    if (addr == REG_CTRL) begin
      v = {29'h00000000, st.alm2_en, st.alm1_en, st.setup};
    end else if (addr == REG_STATUS) begin
      v = {24'h000000, st.wd_pos, st.obj_pos, st.alarm};
    end else if (addr == REG_ALM1_THR) begin
      v = st.alm1_thr;
    end else if (addr == REG_ALM2_THR) begin
      v = st.alm2_thr;
    end else if (addr == REG_WARN_THR) begin
      v = st.warn_thr;
    end else if (addr == REG_ABR_THR) begin
      v = st.abr_thr;
    end else if (addr >= REG_CNT_BASE && addr < REG_IND_SINGLE) begin
      v = st.cnt[2'((addr - REG_CNT_BASE) >> 2)];
    end else if (addr == REG_IND_SINGLE) begin
      v = 32'(st.ind_single);
    end else if (addr == REG_IND_STATUS) begin
      v = 32'(st.ind_stat);
    end else if (addr == REG_IRQ_STAT) begin
      v = 32'(st.irq_stat);
    end else if (addr == REG_IRQ_EN) begin
      v = 32'(st.irq_en);
    end else if (addr == REG_LOG_SEL) begin
      v = {24'h000000, st.used, st.sel};
    end else if (addr == REG_LOG_BASE) begin
      v = e.stamp;
    end else if (addr == REG_LOG_BASE + 8'h04) begin
      v = e.open_time;
    end else if (addr == REG_LOG_BASE + 8'h08) begin
      v = e.close_time;
    end else if (addr == REG_LOG_BASE + 8'h0C) begin
      v = {4'h0, e.event_id, e.breaker_object_function, e.wd, e.open_cause, e.close_cause, e.open_src, e.close_src};
    end else if (addr == REG_LOG_BASE + 8'h10) begin
      v = {28'h0000000, e.gen_status};
    end else if (addr >= REG_RISE_BASE && addr < REG_FALL_BASE) begin
      v = st.rise_en[32 * int'(addr[3:2]) +: 32];
    end else if (addr >= REG_FALL_BASE && addr < REG_FALL_BASE + 8'h10) begin
      v = st.fall_en[32 * int'(addr[3:2]) +: 32];
    end
    return v;
  endfunction

  always_comb begin
    logic [SRC_W-1:0] src;
    logic [SRC_W-1:0] raw_rise;
    logic [SRC_W-1:0] new_on;
    logic [SRC_W-1:0] new_off;
    logic [SRC_W-1:0] srv_on;
    logic [SRC_W-1:0] srv_off;
    logic [2*SRC_W-1:0] cand;
    logic [7:0] idx;
    logic hit;
    logic [1:0] obj_code;
    logic [1:0] wd_code;
    logic [1:0] ic;
    logic cl;
    logic wr_ok;
    logic [IRQ_W-1:0] clr;
    logic [IRQ_W-1:0] set;
    logic log_go;
    logic [7:0] log_ev;
    swg_log_type ent;
    src = '0;
    raw_rise = '0;
    new_on = '0;
    new_off = '0;
    srv_on = '0;
    srv_off = '0;
    cand = '0;
    idx = 8'h00;
    hit = 1'b0;
    obj_code = POS_INTER;
    wd_code = POS_INTER;
    ic = POS_INTER;
    cl = 1'b0;
    clr = '0;
    set = '0;
    log_go = 1'b0;
    log_ev = 8'h00;
    ent = '0;
    next_s = s;
    next_s.tick = 1'b0;
    next_s.evt.valid = 1'b0;

    // bus slave: one wait cycle, write lands on the edge that sees waitrequest low
    wr_ok = AVS_WRITE_IN & ~s.waitreq;
    next_s.waitreq = ~((AVS_READ_IN | AVS_WRITE_IN) & s.waitreq);
    if (AVS_READ_IN & s.waitreq) begin
      next_s.rdata = read_reg(s, AVS_ADDRESS_IN);
    end
    if (wr_ok) begin
      if (AVS_ADDRESS_IN == REG_CTRL) begin
        next_s.setup = AVS_WRITEDATA_IN[CTRL_SETUP];
        next_s.alm1_en = AVS_WRITEDATA_IN[CTRL_ALM1_EN];
        next_s.alm2_en = AVS_WRITEDATA_IN[CTRL_ALM2_EN];
        if (AVS_WRITEDATA_IN[CTRL_CNT_CLR]) begin
          next_s.cnt = '0;
        end
      end else if (AVS_ADDRESS_IN == REG_ALM1_THR) begin
        next_s.alm1_thr = AVS_WRITEDATA_IN;
      end else if (AVS_ADDRESS_IN == REG_ALM2_THR) begin
        next_s.alm2_thr = AVS_WRITEDATA_IN;
      end else if (AVS_ADDRESS_IN == REG_WARN_THR) begin
        next_s.warn_thr = AVS_WRITEDATA_IN;
      end else if (AVS_ADDRESS_IN == REG_ABR_THR) begin
        next_s.abr_thr = AVS_WRITEDATA_IN;
      end else if (AVS_ADDRESS_IN == REG_IND_SINGLE) begin
        if (s.setup) begin
          next_s.ind_single = AVS_WRITEDATA_IN[NI-1:0];
        end
      end else if (AVS_ADDRESS_IN == REG_IRQ_CLR) begin
        clr = AVS_WRITEDATA_IN[IRQ_W-1:0];
      end else if (AVS_ADDRESS_IN == REG_IRQ_EN) begin
        next_s.irq_en = AVS_WRITEDATA_IN[IRQ_W-1:0];
      end else if (AVS_ADDRESS_IN == REG_LOG_SEL) begin
        next_s.sel = AVS_WRITEDATA_IN[3:0] < 4'(LOG_DEPTH) ? AVS_WRITEDATA_IN[3:0] : 4'h0;
      end else if (AVS_ADDRESS_IN >= REG_RISE_BASE && AVS_ADDRESS_IN < REG_FALL_BASE) begin
        next_s.rise_en[32 * int'(AVS_ADDRESS_IN[3:2]) +: 32] = AVS_WRITEDATA_IN;
      end else if (AVS_ADDRESS_IN >= REG_FALL_BASE && AVS_ADDRESS_IN < REG_FALL_BASE + 8'h10) begin
        next_s.fall_en[32 * int'(AVS_ADDRESS_IN[3:2]) +: 32] = AVS_WRITEDATA_IN;
      end
    end

    // millisecond time base for stamps and operating times
    if (s.div >= 32'(MS_CYCLES - 1)) begin
      next_s.div = 32'h00000000;
      next_s.ms = s.ms + 32'h00000001;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 32'h00000001;
    end

    // indicator monitors; no output here reaches a breaker or disconnector
    for (int i = 0; i < NI; i++) begin
      cl = s.ind_single[i] ? ~IND_OPEN_IN[i] : IND_CLOSE_IN[i];
      ic = decode_pos(IND_OPEN_IN[i], cl);
      next_s.ind_stat[i] = ic;
      src[IND_BASE + 4 * i +: 4] = onehot_pos(ic);
    end

    // condition alarms; a disabled alarm stays low whatever the count
    next_s.alarm.alm1 = s.alm1_en && (WEAR_IN.ops_left < s.alm1_thr);
    next_s.alarm.alm2 = s.alm2_en && (WEAR_IN.ops_left < s.alm2_thr);
    next_s.alarm.warn = WEAR_IN.abrasion > s.warn_thr;
    next_s.alarm.abr = WEAR_IN.abrasion > s.abr_thr;

    // breaker event sources
    obj_code = decode_pos(BRK_IN.obj_open, BRK_IN.obj_close);
    wd_code = decode_pos(BRK_IN.wd_out, BRK_IN.wd_in);
    next_s.obj_pos = obj_code;
    next_s.wd_pos = wd_code;
    src[SRC_OBJ_POS +: 4] = onehot_pos(obj_code);
    src[SRC_WD_POS +: 4] = onehot_pos(wd_code);
    src[SRC_OPEN_REQ] = BRK_IN.open_req;
    src[SRC_OPEN_CMD] = BRK_IN.open_cmd;
    src[SRC_CLOSE_REQ] = BRK_IN.close_req;
    src[SRC_CLOSE_CMD] = BRK_IN.close_cmd;
    src[SRC_OPEN_BLK] = BRK_IN.open_blk;
    src[SRC_CLOSE_BLK] = BRK_IN.close_blk;
    src[SRC_READY] = BRK_IN.ready;
    src[SRC_SYNC_OK] = BRK_IN.sync_ok;
    src[SRC_OPEN_FAIL] = BRK_IN.open_fail;
    src[SRC_CLOSE_FAIL] = BRK_IN.close_fail;
    src[SRC_FINAL_TRIP] = BRK_IN.final_trip;
    src[SRC_ABR_ALARM] = s.alarm.abr;
    src[SRC_OPTIME_EXC] = BRK_IN.optime_exc;
    src[SRC_CBR_LOC] = BRK_IN.cbr_loc;
    src[SRC_SWI_LOC] = BRK_IN.swi_loc;
    src[SRC_ALM1] = s.alarm.alm1;
    src[SRC_ALM2] = s.alarm.alm2;
    src[SRC_TCS] = BRK_IN.tcs_alarm;
    src[SRC_WEAR_WARN] = s.alarm.warn;

    // edge filter: only selected edges reach the event buffer
    raw_rise = src & ~s.src_prev;
    new_on = raw_rise & s.rise_en;
    new_off = ~src & s.src_prev & s.fall_en;
    next_s.src_prev = src;

    // a burst shares the stamp taken when it began; drain takes at most 2*SRC_W cycles
    if (s.pend_on == '0 && s.pend_off == '0) begin
      next_s.stamp = s.ms;
    end
    cand = {s.pend_off, s.pend_on};
    for (int i = 2 * SRC_W - 1; i >= 0; i--) begin
      if (cand[i]) begin
        hit = 1'b1;
        idx = 8'(i);
      end
    end
    if (hit) begin
      next_s.evt.valid = 1'b1;
      next_s.evt.on = ~idx[7];
      next_s.evt.id = idx[6:0];
      next_s.evt.stamp = s.stamp;
      if (idx[7]) begin
        srv_off[idx[6:0]] = 1'b1;
      end else begin
        srv_on[idx[6:0]] = 1'b1;
      end
    end
    // new edges win over the serve of the same source
    next_s.pend_on = (s.pend_on & ~srv_on) | new_on;
    next_s.pend_off = (s.pend_off & ~srv_off) | new_off;

    // operation counters count after any clear, so a coincident event survives
    if (raw_rise[SRC_OBJ_POS + int'(POS_OPEN)]) begin
      next_s.cnt[CNT_OPEN] = next_s.cnt[CNT_OPEN] + 32'h00000001;
    end
    if (raw_rise[SRC_OBJ_POS + int'(POS_CLOSED)]) begin
      next_s.cnt[CNT_CLOSE] = next_s.cnt[CNT_CLOSE] + 32'h00000001;
    end
    if (raw_rise[SRC_OPEN_FAIL]) begin
      next_s.cnt[CNT_OFAIL] = next_s.cnt[CNT_OFAIL] + 32'h00000001;
    end
    if (raw_rise[SRC_CLOSE_FAIL]) begin
      next_s.cnt[CNT_CFAIL] = next_s.cnt[CNT_CFAIL] + 32'h00000001;
    end

    // operating time in ms from command edge to reported position
    if (raw_rise[SRC_OPEN_CMD]) begin
      next_s.o_run = 1'b1;
      next_s.o_time = 32'h00000000;
    end else if (s.o_run && raw_rise[SRC_OBJ_POS + int'(POS_OPEN)]) begin
      next_s.o_run = 1'b0;
      next_s.o_last = s.o_time;
    end else if (s.o_run && s.tick) begin
      next_s.o_time = s.o_time + 32'h00000001;
    end
    if (raw_rise[SRC_CLOSE_CMD]) begin
      next_s.c_run = 1'b1;
      next_s.c_time = 32'h00000000;
    end else if (s.c_run && raw_rise[SRC_OBJ_POS + int'(POS_CLOSED)]) begin
      next_s.c_run = 1'b0;
      next_s.c_last = s.c_time;
    end else if (s.c_run && s.tick) begin
      next_s.c_time = s.c_time + 32'h00000001;
    end

    // operation log: position reached or command failed
    if (raw_rise[SRC_OPEN_FAIL]) begin
      log_go = 1'b1;
      log_ev = 8'(SRC_OPEN_FAIL);
    end else if (raw_rise[SRC_CLOSE_FAIL]) begin
      log_go = 1'b1;
      log_ev = 8'(SRC_CLOSE_FAIL);
    end else if (raw_rise[SRC_OBJ_POS + int'(POS_OPEN)]) begin
      log_go = 1'b1;
      log_ev = 8'(SRC_OBJ_POS + int'(POS_OPEN));
    end else if (raw_rise[SRC_OBJ_POS + int'(POS_CLOSED)]) begin
      log_go = 1'b1;
      log_ev = 8'(SRC_OBJ_POS + int'(POS_CLOSED));
    end
    if (log_go) begin
      ent.stamp = s.ms;
      ent.open_time = next_s.o_last;
      ent.close_time = next_s.c_last;
      ent.event_id = log_ev;
      ent.breaker_object_function = obj_code;
      ent.wd = wd_code;
      ent.open_cause = BRK_IN.open_cause;
      ent.close_cause = BRK_IN.close_cause;
      ent.open_src = BRK_IN.open_src;
      ent.close_src = BRK_IN.close_src;
      ent.gen_status = BRK_IN.gen_status;
      next_s.log_mem[s.wp] = ent;
      next_s.wp = (s.wp == 4'(LOG_DEPTH - 1)) ? 4'h0 : s.wp + 4'h1;
      if (s.used != 4'(LOG_DEPTH)) begin
        next_s.used = s.used + 4'h1;
      end
    end

    // sticky interrupt causes; a set in the clearing cycle wins
    set[IRQ_ALM1] = next_s.alarm.alm1 & ~s.alarm.alm1;
    set[IRQ_ALM2] = next_s.alarm.alm2 & ~s.alarm.alm2;
    set[IRQ_WARN] = next_s.alarm.warn & ~s.alarm.warn;
    set[IRQ_ABR] = next_s.alarm.abr & ~s.alarm.abr;
    set[IRQ_LOG] = log_go;
    set[IRQ_FAIL] = raw_rise[SRC_OPEN_FAIL] | raw_rise[SRC_CLOSE_FAIL];
    next_s.irq_stat = (s.irq_stat & ~clr) | set;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
  end

  // single state register; reset gives documented defaults
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.alm1_thr <= ALM1_THR_RST;
      s.alm2_thr <= ALM2_THR_RST;
      s.warn_thr <= WARN_THR_RST;
      s.abr_thr <= ABR_THR_RST;
      s.rise_en <= '1;
      s.fall_en <= '1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign AVS_READDATA_OUT = s.rdata;
  assign AVS_WAITREQUEST_OUT = s.waitreq;
  assign EVT_OUT = s.evt;
  assign ALARM_OUT = s.alarm;
  assign IND_STATUS_OUT = s.ind_stat;
  assign IRQ_OUT = s.irq;

endmodule
`default_nettype wire

// ===== logic/swg_pkg.sv
// Purpose: constants, register map and carrier types for the switchgear status and event log block
// Assumes: 200 MHz system clock, Avalon-MM slave with 32-bit data and byte addresses
// Notes: event sources 0..31 belong to the breaker object, 32 upward to the position indicators
//
// Behaviour
// - alarm 2 when enabled and operations-left below threshold
// - wear warning when abrasion exceeds warning threshold
// - per source, store only enabled rising/falling edges
// - every event carries the stamp taken when its burst began
// - open/close/fail counters, all cleared together by software
// - events on position, carriage, request, command, ready, sync
// - events on failures, trip, wear, timing, local, alarms
// - rolling twelve-entry log, oldest overwritten first
// - log entry holds stamp, event, statuses, causes, sources
// - opening and closing times measured and logged
// - neither input intermediate, both inputs bad
// - indicator monitor has no command outputs
// - indicator open/close/bad/intermediate events, 1 ms stamps
// - single input mode uses inverted copy for close
// - indicator settings change only during setup
package swg_pkg;

  // time stamp rate
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;

  localparam int LOG_DEPTH = 12;
  localparam int SRC_W = 128;
  localparam int IND_BASE = 32;
  localparam int IRQ_W = 6;

  // threshold reset values
  localparam logic [31:0] ALM1_THR_RST = 32'h000003E8;
  localparam logic [31:0] ALM2_THR_RST = 32'h00000064;
  localparam logic [31:0] WARN_THR_RST = 32'h00030D40;
  localparam logic [31:0] ABR_THR_RST = 32'h00030D40;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ALM1_THR = 8'h08;
  localparam logic [7:0] REG_ALM2_THR = 8'h0C;
  localparam logic [7:0] REG_WARN_THR = 8'h10;
  localparam logic [7:0] REG_ABR_THR = 8'h14;
  localparam logic [7:0] REG_CNT_BASE = 8'h18;
  localparam logic [7:0] REG_IND_SINGLE = 8'h28;
  localparam logic [7:0] REG_IND_STATUS = 8'h2C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h30;
  localparam logic [7:0] REG_IRQ_CLR = 8'h34;
  localparam logic [7:0] REG_IRQ_EN = 8'h38;
  localparam logic [7:0] REG_LOG_SEL = 8'h3C;
  localparam logic [7:0] REG_LOG_BASE = 8'h40;
  localparam logic [7:0] REG_RISE_BASE = 8'h60;
  localparam logic [7:0] REG_FALL_BASE = 8'h70;

  // control bits
  localparam int CTRL_SETUP = 0;
  localparam int CTRL_ALM1_EN = 1;
  localparam int CTRL_ALM2_EN = 2;
  localparam int CTRL_CNT_CLR = 3;

  // counter indices
  localparam int CNT_OPEN = 0;
  localparam int CNT_CLOSE = 1;
  localparam int CNT_OFAIL = 2;
  localparam int CNT_CFAIL = 3;

  // interrupt bits
  localparam int IRQ_ALM1 = 0;
  localparam int IRQ_ALM2 = 1;
  localparam int IRQ_WARN = 2;
  localparam int IRQ_ABR = 3;
  localparam int IRQ_LOG = 4;
  localparam int IRQ_FAIL = 5;

  // breaker event source indices
  localparam int SRC_OBJ_POS = 0;
  localparam int SRC_WD_POS = 4;
  localparam int SRC_OPEN_REQ = 8;
  localparam int SRC_OPEN_CMD = 9;
  localparam int SRC_CLOSE_REQ = 10;
  localparam int SRC_CLOSE_CMD = 11;
  localparam int SRC_OPEN_BLK = 12;
  localparam int SRC_CLOSE_BLK = 13;
  localparam int SRC_READY = 14;
  localparam int SRC_SYNC_OK = 15;
  localparam int SRC_OPEN_FAIL = 16;
  localparam int SRC_CLOSE_FAIL = 17;
  localparam int SRC_FINAL_TRIP = 18;
  localparam int SRC_ABR_ALARM = 19;
  localparam int SRC_OPTIME_EXC = 20;
  localparam int SRC_CBR_LOC = 21;
  localparam int SRC_SWI_LOC = 22;
  localparam int SRC_ALM1 = 23;
  localparam int SRC_ALM2 = 24;
  localparam int SRC_TCS = 25;
  localparam int SRC_WEAR_WARN = 26;

  // position codes, also the bit order of the one-hot source groups
  localparam logic [1:0] POS_INTER = 2'h0;
  localparam logic [1:0] POS_OPEN = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_BAD = 2'h3;

  typedef struct packed {
    logic obj_open;
    logic obj_close;
    logic wd_out;
    logic wd_in;
    logic open_req;
    logic open_cmd;
    logic close_req;
    logic close_cmd;
    logic open_blk;
    logic close_blk;
    logic ready;
    logic sync_ok;
    logic open_fail;
    logic close_fail;
    logic final_trip;
    logic optime_exc;
    logic cbr_loc;
    logic swi_loc;
    logic tcs_alarm;
    logic [3:0] open_cause;
    logic [3:0] close_cause;
    logic [3:0] open_src;
    logic [3:0] close_src;
    logic [3:0] gen_status;
  } swg_brk_type;

  typedef struct packed {
    logic [31:0] ops_left;
    logic [31:0] abrasion;
  } swg_wear_type;

  typedef struct packed {
    logic valid;
    logic on;
    logic [6:0] id;
    logic [31:0] stamp;
  } swg_evt_type;

  typedef struct packed {
    logic alm1;
    logic alm2;
    logic warn;
    logic abr;
  } swg_alarm_type;

  typedef struct packed {
    logic [31:0] stamp;
    logic [31:0] open_time;
    logic [31:0] close_time;
    logic [7:0] event_id;
    logic [1:0] breaker_object_function;
    logic [1:0] wd;
    logic [3:0] open_cause;
    logic [3:0] close_cause;
    logic [3:0] open_src;
    logic [3:0] close_src;
    logic [3:0] gen_status;
  } swg_log_type;

  // open/close contact pair to position code
  function automatic logic [1:0] decode_pos(input logic open_act, input logic close_act);
    return {close_act, open_act};
  endfunction

  function automatic logic [3:0] onehot_pos(input logic [1:0] code);
    return 4'h1 << code;
  endfunction

endpackage

// ===== testbench/swg_chk.sv
// Purpose: port-level checks for the switchgear status block
// Assumes: one clock domain, async active-low reset
// Notes: indicator 0 is never put in single-input mode by the bench
`timescale 1ns/1ps
`default_nettype none
module swg_chk import swg_pkg::*; #(parameter int NI = 10) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire swg_pkg::swg_wear_type WEAR_IN,
  input wire logic [NI-1:0] IND_OPEN_IN,
  input wire logic [NI-1:0] IND_CLOSE_IN,
  input wire swg_pkg::swg_evt_type EVT_OUT,
  input wire swg_pkg::swg_alarm_type ALARM_OUT,
  input wire logic [2*NI-1:0] IND_STATUS_OUT,
  input wire logic IRQ_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  // bus: exactly one wait cycle, then a single low cycle
  property p_wait_one; (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_wait_pulse; !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("wait low too long");
  property p_rd_hold; !$past(AVS_READ_IN) |-> $stable(AVS_READDATA_OUT); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  // status code follows the contact pair one edge later
  property p_ind_code; $past(RST_N_IN) |-> IND_STATUS_OUT[1:0] == $past({IND_CLOSE_IN[0], IND_OPEN_IN[0]}); endproperty
  a_ind_code: assert property (p_ind_code) else $error("indicator code wrong");
  property p_evt_range;
    EVT_OUT.valid |-> EVT_OUT.id <= 7'd26 || (EVT_OUT.id >= 7'd32 && EVT_OUT.id < 7'(32 + 4 * NI));
  endproperty
  a_evt_range: assert property (p_evt_range) else $error("event id out of range");
  property p_ind_evt;
    $rose(IND_OPEN_IN[0]) && !IND_CLOSE_IN[0] |-> ##[1:40] EVT_OUT.valid && EVT_OUT.id == 7'd33 && EVT_OUT.on;
  endproperty
  a_ind_evt: assert property (p_ind_evt) else $error("open event missing");
  // zero abrasion: no warning
  property p_warn_zero; WEAR_IN.abrasion == 32'h0 [*3] |-> !ALARM_OUT.warn; endproperty
  a_warn_zero: assert property (p_warn_zero) else $error("warning without abrasion");
  property p_alm2_full; WEAR_IN.ops_left == 32'hFFFFFFFF [*3] |-> !ALARM_OUT.alm2; endproperty
  a_alm2_full: assert property (p_alm2_full) else $error("alarm 2 with full life");
  c_read: cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
  c_evt: cover property (EVT_OUT.valid && EVT_OUT.id == 7'd33);
  c_alm: cover property ($rose(ALARM_OUT.alm2));
  c_irq: cover property (IRQ_OUT);
endmodule
bind swg_status_event_log swg_chk #(.NI(NI)) swg_chk_inst (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .WEAR_IN(WEAR_IN), .IND_OPEN_IN(IND_OPEN_IN),
  .IND_CLOSE_IN(IND_CLOSE_IN), .EVT_OUT(EVT_OUT), .ALARM_OUT(ALARM_OUT), .IND_STATUS_OUT(IND_STATUS_OUT),
  .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ===== testbench/swg_aux_contacts.sv
// Purpose: auxiliary contact model feeding the indicator position inputs
// Assumes: one open and one close contact per indicator
// Notes: in single-input mode the close pin is unwired and picks up the open level
`timescale 1ns/1ps
`default_nettype none
module swg_aux_contacts #(parameter int NI = 10) (
  input wire logic [NI-1:0] want_open_in,
  input wire logic [NI-1:0] want_close_in,
  input wire logic [NI-1:0] single_in,
  output logic [NI-1:0] open_out,
  output logic [NI-1:0] close_out
);
  // a made contact drives its pin high
  assign open_out = want_open_in;
  // a design reading the unwired pin would see bad when open and intermediate otherwise, not the inverted copy
  assign close_out = (want_close_in & ~single_in) | (want_open_in & single_in);
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: directed bench for the switchgear status and event log block
// Assumes: one ms shortened to 20 cycles, ten indicators
// Notes: every wait is bounded; a spent bound counts as a mismatch except where the event is expected not to come
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import swg_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wait_r, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, t0, stamp;
  swg_brk_type brk = '0;
  swg_wear_type wear = {32'hFFFFFFFF, 32'h0};
  logic [9:0] w_open = 10'h0, w_close = 10'h0, single = 10'h0, p_open, p_close;
  logic [19:0] status;
  swg_evt_type evt;
  swg_alarm_type alarm;
  int error_cnt = 0, checked = 0;
  initial forever #2.5 clk = ~clk;
  swg_status_event_log #(.NI(10), .MS_CYCLES(20)) swg_status_event_log_inst (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(wait_r), .BRK_IN(brk), .WEAR_IN(wear), .IND_OPEN_IN(p_open), .IND_CLOSE_IN(p_close),
    .EVT_OUT(evt), .ALARM_OUT(alarm), .IND_STATUS_OUT(status), .IRQ_OUT(irq));
  swg_aux_contacts #(.NI(10)) swg_aux_contacts_inst (.want_open_in(w_open), .want_close_in(w_close),
    .single_in(single), .open_out(p_open), .close_out(p_close));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus access; a read compares against d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      summarize();
    end
    if (!w) check(rdata, d);
    @(posedge clk);
  endtask
  // one event within 40 edges; want says if it should come
  task automatic expect_evt(input logic [6:0] id, input logic on, input logic want);
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(evt.valid === 1'b1 && evt.id === id && evt.on === on) && n < 40);
    stamp = evt.stamp;
    check(n < 40, want);
  endtask
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, REG_ALM2_THR, 32'h00000064);
    bus(0, REG_WARN_THR, 32'h00030D40);
    bus(0, REG_RISE_BASE, 32'hFFFFFFFF);
    bus(0, 8'hFC, 32'h0);
    // alarm 2 at and under threshold, irq masked then enabled
    bus(1, REG_CTRL, 32'h4);
    wear.ops_left <= 32'd100;
    repeat (4) @(posedge clk);
    check(alarm.alm2, 1'b0);
    wear.ops_left <= 32'd99;
    repeat (4) @(posedge clk);
    check(alarm.alm2, 1'b1);
    check(irq, 1'b0);
    bus(1, REG_IRQ_EN, 32'h2);
    check(irq, 1'b1);
    bus(1, REG_IRQ_CLR, 32'h2);
    check(irq, 1'b0);
    wear.abrasion <= 32'd200000;
    repeat (4) @(posedge clk);
    check(alarm.warn, 1'b0);
    wear.abrasion <= 32'd200001;
    repeat (4) @(posedge clk);
    check(alarm.warn, 1'b1);
    // indicator 0 through all four states, bad rise filtered out
    bus(1, REG_RISE_BASE + 8'h04, 32'hFFFFFFF7);
    w_open[0] <= 1'b1;
    expect_evt(7'd33, 1'b1, 1'b1);
    t0 = stamp;
    check(status[1:0], POS_OPEN);
    repeat (60) @(posedge clk);
    w_close[0] <= 1'b1;
    expect_evt(7'd35, 1'b1, 1'b0);
    check(status[1:0], POS_BAD);
    w_open[0] <= 1'b0;
    w_close[0] <= 1'b0;
    expect_evt(7'd32, 1'b1, 1'b1);
    check(stamp > t0, 1'b1);
    check(status[1:0], POS_INTER);
    w_close[0] <= 1'b1;
    expect_evt(7'd34, 1'b1, 1'b1);
    check(status[1:0], POS_CLOSED);
    // single input mode for indicator 1, locked outside setup
    bus(1, REG_CTRL, 32'h5);
    bus(1, REG_IND_SINGLE, 32'h2);
    bus(1, REG_CTRL, 32'h4);
    bus(1, REG_IND_SINGLE, 32'h0);
    bus(0, REG_IND_SINGLE, 32'h2);
    single[1] <= 1'b1;
    w_open[1] <= 1'b1;
    repeat (3) @(posedge clk);
    check(status[3:2], POS_OPEN);
    w_open[1] <= 1'b0;
    repeat (3) @(posedge clk);
    check(status[3:2], POS_CLOSED);
    // breaker: close, then open; 60 counting edges hold exactly three ms ticks
    brk.obj_close <= 1'b1;
    repeat (3) @(posedge clk);
    brk.open_cmd <= 1'b1;
    brk.obj_close <= 1'b0;
    repeat (61) @(posedge clk);
    brk.obj_open <= 1'b1;
    repeat (5) @(posedge clk);
    bus(0, REG_LOG_SEL, 32'h20);
    bus(0, REG_LOG_BASE + 8'h04, 32'd3);
    bus(0, REG_CNT_BASE + 8'h04, 32'd1);
    bus(0, REG_STATUS, 32'h00000017);
    brk.final_trip <= 1'b1;
    expect_evt(7'd18, 1'b1, 1'b1);
    brk.open_req <= 1'b1;
    expect_evt(7'd8, 1'b1, 1'b1);
    for (int i = 0; i < 12; i++) begin
      brk.obj_open <= 1'b0;
      repeat (3) @(posedge clk);
      brk.obj_open <= 1'b1;
      repeat (3) @(posedge clk);
    end
    bus(0, REG_LOG_SEL, 32'hC0);
    bus(0, REG_CNT_BASE, 32'd13);
    bus(1, REG_CTRL, 32'hC);
    bus(0, REG_CNT_BASE, 32'd0);
    summarize();
  end
endmodule
`default_nettype wire
